// >>> rtl/hss_pkg.sv
// Shared constants, register map and types of the hot-swap supervisor
package hss_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int MEAS_PERIOD_US = 1000;
  localparam int MEAS_PERIOD_CYC = MEAS_PERIOD_US * CLK_MHZ;
  localparam int PULSE_US = 20;
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int RESTART_US = 50000;
  localparam int RESTART_CYC = RESTART_US * CLK_MHZ;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_OPERATION = 8'h03;
  localparam logic [7:0] CMD_OT_FAULT = 8'h4F;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [7:0] CMD_TEMP = 8'h8D;
  localparam logic [7:0] CMD_ALERT_MASK = 8'hD8;
  localparam logic [7:0] CMD_SETUP = 8'hD9;
  localparam logic [7:0] CMD_FAULT_WORD = 8'hE1;
  localparam logic [7:0] CMD_CLEAR = 8'hF0;
  // ==========================================================
  // Reset values and encodings
  localparam logic [7:0] OP_ON = 8'h80;
  localparam logic [7:0] OP_OFF = 8'h00;
  localparam logic [15:0] OT_FAULT_RST = 16'h0096;
  localparam logic [15:0] OT_WARN_RST = 16'h007D;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [2:0] RETRY_INF = 3'h6;
  localparam logic [6:0] ADDR_BASE = 7'h40;
  localparam logic [6:0] STRAP_MUL2 = 7'h09;
  localparam logic [6:0] STRAP_MUL1 = 7'h03;
  // ==========================================================
  // Bit positions of the combined fault word
  localparam int DG_OC = 0;
  localparam int DG_UV = 1;
  localparam int DG_OV = 2;
  localparam int DG_OTW = 3;
  localparam int DG_OTF = 4;
  localparam int DG_SHORT = 5;
  localparam int DG_LATCH = 6;
  localparam int DG_PGOOD = 7;
  localparam int FLAG_W = 6;
  // Bit positions of the summary and vendor status words
  localparam int SW_OTHER = 0;
  localparam int SW_TEMP = 2;
  localparam int SW_OFF = 6;
  localparam int SW_PGOOD_N = 11;
  localparam int SW_INPUT = 13;
  localparam int VS_SHORT = 0;
  // ==========================================================
  // Bus target states
  typedef enum logic [2:0] {
    SM_IDLE = 3'b000,
    SM_ADDR = 3'b001,
    SM_WBYTE = 3'b010,
    SM_ACKW = 3'b011,
    SM_ACK = 3'b100,
    SM_RBYTE = 3'b101,
    SM_RACK = 3'b110,
    SM_RLOAD = 3'b111
  } hss_smb_state_type;
endpackage : hss_pkg

// >>> rtl/hss_smb_target.sv
// Byte-level SMBus target: start/stop, address match, shifting and acknowledge
`timescale 1ns/1ns
module hss_smb_target (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n_out,
  // Address
  input wire logic addr_valid_in,
  input wire logic [6:0] addr_in,
  // Byte side
  output logic start_out,
  output logic stop_out,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  output logic [1:0] byte_idx_out,
  output logic is_read_out,
  output logic rd_idx_out,
  input wire logic [7:0] rd_data_in
);
  import hss_pkg::*;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det, rw;
  logic [2:0] cnt;
  logic [1:0] wcnt;
  logic [7:0] shift, nb;
  hss_smb_state_type state;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign nb = {shift[6:0], sda_s2};

  // ==========================================================
  // Transfer sequencer
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= SM_IDLE;
      cnt <= 3'h0;
      wcnt <= 2'h0;
      shift <= 8'h00;
      rw <= 1'b0;
      sda_oe_n_out <= 1'b1;
      start_out <= 1'b0;
      stop_out <= 1'b0;
      byte_valid_out <= 1'b0;
      byte_out <= 8'h00;
      byte_idx_out <= 2'h0;
      is_read_out <= 1'b0;
      rd_idx_out <= 1'b0;
    end else begin
      start_out <= start_det;
      stop_out <= stop_det;
      byte_valid_out <= 1'b0;
      if (start_det) begin
        state <= SM_ADDR;
        cnt <= 3'h0;
        sda_oe_n_out <= 1'b1;
        is_read_out <= 1'b0;
        rd_idx_out <= 1'b0;
      end else if (stop_det) begin
        state <= SM_IDLE;
        sda_oe_n_out <= 1'b1;
        wcnt <= 2'h0;
      end else begin
        case (state)
          SM_ADDR, SM_WBYTE: begin
            if (scl_rise) begin
              shift <= nb;
              cnt <= cnt + 3'h1;
              if (cnt == 3'h7) begin
                state <= SM_ACKW;
                if (state == SM_ADDR) begin
                  rw <= nb[0];
                  is_read_out <= nb[0];
                  if (!addr_valid_in || nb[7:1] != addr_in) begin
                    state <= SM_IDLE;
                  end
                end else begin
                  byte_valid_out <= 1'b1;
                  byte_out <= nb;
                  byte_idx_out <= wcnt;
                  if (wcnt != 2'h3) begin
                    wcnt <= wcnt + 2'h1;
                  end
                end
              end
            end
          end
          SM_ACKW: begin
            if (scl_fall) begin
              sda_oe_n_out <= 1'b0;
              state <= SM_ACK;
            end
          end
          SM_ACK, SM_RLOAD: begin
            if (scl_fall) begin
              if (rw) begin
                sda_oe_n_out <= rd_data_in[7];
                shift <= {rd_data_in[6:0], 1'b0};
                cnt <= 3'h0;
                state <= SM_RBYTE;
              end else begin
                sda_oe_n_out <= 1'b1;
                state <= SM_WBYTE;
              end
            end
          end
          SM_RBYTE: begin
            if (scl_fall) begin
              cnt <= cnt + 3'h1;
              if (cnt == 3'h7) begin
                sda_oe_n_out <= 1'b1;
                state <= SM_RACK;
              end else begin
                sda_oe_n_out <= shift[7];
                shift <= {shift[6:0], 1'b0};
              end
            end
          end
          SM_RACK: begin
            if (scl_rise) begin
              // A not-acknowledge ends the read; extra bytes repeat the high byte
              state <= sda_s2 ? SM_IDLE : SM_RLOAD;
              rd_idx_out <= 1'b1;
            end
          end
          default: state <= SM_IDLE;
        endcase
      end
    end
  end
endmodule : hss_smb_target

// >>> rtl/hss_status_top.sv
// Supervision logic of the hot-swap controller: gate, power good, faults, alert, bus registers
`timescale 1ns/1ns
module hss_status_top #(
  parameter int MEAS_CYC = hss_pkg::MEAS_PERIOD_CYC,
  parameter int PULSE_LEN = hss_pkg::PULSE_CYC,
  parameter int RESTART_LEN = hss_pkg::RESTART_CYC
) (
  // Clock and power-on reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic alert_out_n,
  output logic alert_oe_n_out,
  // Comparator inputs from the analog side
  input wire logic undervolt_enable_in,
  input wire logic overvolt_lockout_in,
  input wire logic feedback_in,
  input wire logic sense_over_in,
  input wire logic fault_timeout_in,
  input wire logic ref_ok_in,
  input wire logic [1:0] addr_strap_0_in,
  input wire logic [1:0] addr_strap_1_in,
  input wire logic [1:0] addr_strap_2_in,
  // Temperature converter, same clock
  input wire logic [15:0] temp_code_in,
  // Drive outputs
  output logic gate_on_out,
  output logic power_good_out,
  output logic diode_pulse_out
);
  import hss_pkg::*;
  localparam int MW = $clog2(MEAS_CYC);
  localparam int PW = $clog2(PULSE_LEN + 1);
  localparam int RW = $clog2(RESTART_LEN + 1);

  logic [11:0] async_v, sync1, sync2;
  logic uv_ok, ov_hi, fb_ok, sense_hi, tmo, ref_ok;
  logic [1:0] s0, s1, s2;
  logic uv_d, tmo_d, soft_rst;
  logic [6:0] addr;
  logic addr_valid;
  logic [7:0] op, setup;
  logic [15:0] ot_fault_lim, ot_warn_lim, mask, temp;
  logic [FLAG_W-1:0] flags, set_vec;
  logic clr;
  logic rearm, latched, retry_wait;
  logic [4:0] retry_left;
  logic [MW-1:0] meas_cnt;
  logic [PW-1:0] pulse_cnt;
  logic [RW-1:0] restart_cnt;
  logic temp_new;
  logic start_p, stop_p, bv, is_read, rd_idx;
  logic [7:0] bdata, rd_data, cmd, d0;
  logic [1:0] bidx, nbytes;
  logic [15:0] rd_word, fault_word, status_word;
  logic next_gate;

  // ==========================================================
  // Synchronisers for every comparator and strap input; the bus pins are synchronised in the target
  assign async_v = {undervolt_enable_in, overvolt_lockout_in, feedback_in,
                    sense_over_in, fault_timeout_in, ref_ok_in,
                    addr_strap_2_in, addr_strap_1_in, addr_strap_0_in};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1 <= 12'h000;
      sync2 <= 12'h000;
    end else begin
      sync1 <= async_v;
      sync2 <= sync1;
    end
  end

  assign {uv_ok, ov_hi, fb_ok, sense_hi, tmo, ref_ok, s2, s1, s0} = sync2;
  // Reference pin held low acts as a logic reset
  assign soft_rst = ~ref_ok;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      uv_d <= 1'b0;
      tmo_d <= 1'b0;
    end else begin
      uv_d <= uv_ok;
      tmo_d <= tmo;
    end
  end

  // ==========================================================
  // Address capture from the straps
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr <= ADDR_BASE;
      addr_valid <= 1'b0;
    end else if (soft_rst) begin
      addr_valid <= 1'b0;
    end else if (!addr_valid) begin
      // Taken once after power-on reset or reference release
      addr <= ADDR_BASE + {5'h00, s2} * STRAP_MUL2
              + {5'h00, s1} * STRAP_MUL1 + {5'h00, s0};
      addr_valid <= 1'b1;
    end
  end

  // ==========================================================
  // Bus target
  hss_smb_target u_smb (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_n_out(sda_oe_n_out),
    .addr_valid_in(addr_valid),
    .addr_in(addr),
    .start_out(start_p),
    .stop_out(stop_p),
    .byte_valid_out(bv),
    .byte_out(bdata),
    .byte_idx_out(bidx),
    .is_read_out(is_read),
    .rd_idx_out(rd_idx),
    .rd_data_in(rd_data)
  );

  // Pin is open-drain: the data level never leaves zero
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Command and data byte capture
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd <= 8'h00;
      d0 <= 8'h00;
      nbytes <= 2'h0;
    end else if (stop_p) begin
      nbytes <= 2'h0;
    end else if (bv) begin
      nbytes <= bidx;
      if (bidx == 2'h0) begin
        cmd <= bdata;
      end else if (bidx == 2'h1) begin
        d0 <= bdata;
      end
    end
  end

  // ==========================================================
  // Host registers, committed at the stop condition
  // Undervoltage and overvoltage inputs never touch these
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op <= OP_ON;
      setup <= SETUP_RST;
      ot_fault_lim <= OT_FAULT_RST;
      ot_warn_lim <= OT_WARN_RST;
      mask <= MASK_RST;
    end else if (soft_rst) begin
      op <= OP_ON;
      setup <= SETUP_RST;
      ot_fault_lim <= OT_FAULT_RST;
      ot_warn_lim <= OT_WARN_RST;
      mask <= MASK_RST;
    end else if (stop_p && !is_read) begin
      if (nbytes != 2'h0) begin
        case (cmd)
          CMD_OPERATION: op <= d0;
          CMD_SETUP: setup <= d0;
          default: ;
        endcase
      end
      if (nbytes == 2'h2) begin
        case (cmd)
          CMD_OT_FAULT: ot_fault_lim <= {bdata, d0};
          CMD_OT_WARN: ot_warn_lim <= {bdata, d0};
          CMD_ALERT_MASK: mask <= {bdata, d0};
          default: ;
        endcase
      end
    end
  end

  // Send-byte to the clear code drops all sticky flags
  assign clr = stop_p && !is_read && nbytes == 2'h0 && cmd == CMD_CLEAR;

  // ==========================================================
  // Temperature measurement pacing
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meas_cnt <= '0;
      pulse_cnt <= '0;
      diode_pulse_out <= 1'b0;
      temp_new <= 1'b0;
    end else begin
      temp_new <= 1'b0;
      if (meas_cnt == MW'(MEAS_CYC - 1)) begin
        meas_cnt <= '0;
        diode_pulse_out <= 1'b1;
        pulse_cnt <= PW'(PULSE_LEN);
      end else begin
        meas_cnt <= meas_cnt + MW'(1);
      end
      if (diode_pulse_out && pulse_cnt == PW'(1)) begin
        diode_pulse_out <= 1'b0;
        temp_new <= 1'b1;
      end else if (pulse_cnt != '0) begin
        pulse_cnt <= pulse_cnt - PW'(1);
      end
    end
  end

  // Result is taken as the high current step ends
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      temp <= 16'h0000;
    end else if (soft_rst) begin
      temp <= 16'h0000;
    end else if (temp_new) begin
      temp <= temp_code_in;
    end
  end

  // ==========================================================
  // Sticky fault flags; a set in the clear cycle survives
  always_comb begin
    set_vec = '0;
    set_vec[DG_OC] = tmo & ~tmo_d;
    set_vec[DG_UV] = ~uv_ok;
    set_vec[DG_OV] = ov_hi;
    set_vec[DG_OTW] = temp_new && $signed(temp_code_in) > $signed(ot_warn_lim);
    set_vec[DG_OTF] = temp_new && $signed(temp_code_in) > $signed(ot_fault_lim);
    set_vec[DG_SHORT] = sense_hi & ~gate_on_out;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags <= '0;
    end else if (soft_rst) begin
      flags <= '0;
    end else begin
      flags <= (clr ? '0 : flags) | set_vec;
    end
  end

  // ==========================================================
  // Retry bookkeeping after a fault timeout
  function automatic logic [4:0] retry_limit(input logic [2:0] code);
    case (code)
      3'h0: retry_limit = 5'h00;
      3'h1: retry_limit = 5'h01;
      3'h2: retry_limit = 5'h02;
      3'h3: retry_limit = 5'h04;
      3'h4: retry_limit = 5'h08;
      default: retry_limit = 5'h10;
    endcase
  endfunction : retry_limit

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      latched <= 1'b0;
      retry_wait <= 1'b0;
      retry_left <= 5'h00;
      restart_cnt <= '0;
    end else if (soft_rst || (uv_d && !uv_ok)) begin
      // Enable pin pulled low reloads retries and frees the latch
      latched <= 1'b0;
      retry_wait <= 1'b0;
      retry_left <= retry_limit(setup[2:0]);
      restart_cnt <= '0;
    end else if (set_vec[DG_OC]) begin
      if (setup[2:0] >= RETRY_INF || retry_left != 5'h00) begin
        retry_wait <= 1'b1;
        restart_cnt <= RW'(RESTART_LEN);
        if (setup[2:0] < RETRY_INF) begin
          retry_left <= retry_left - 5'h01;
        end
      end else begin
        latched <= 1'b1;
      end
    end else if (retry_wait) begin
      if (restart_cnt == RW'(1)) begin
        retry_wait <= 1'b0;
      end
      restart_cnt <= restart_cnt - RW'(1);
    end
  end

  // Over-temperature shutdown needs an off-then-on operation write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rearm <= 1'b0;
    end else if (soft_rst) begin
      rearm <= 1'b0;
    end else if (set_vec[DG_OTF]) begin
      rearm <= 1'b1;
    end else if (stop_p && !is_read && cmd == CMD_OPERATION && d0 == OP_OFF) begin
      rearm <= 1'b0;
    end
  end

  // ==========================================================
  // Gate, power good and alert drive
  assign next_gate = op[7] && uv_ok && !ov_hi
                     && !flags[DG_OTF] && !rearm
                     && !latched && !retry_wait;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gate_on_out <= 1'b0;
      power_good_out <= 1'b0;
      alert_out_n <= 1'b1;
      alert_oe_n_out <= 1'b1;
    end else begin
      gate_on_out <= next_gate && !soft_rst;
      power_good_out <= fb_ok && uv_ok && !ov_hi;
      // Stays low until every unmasked flag is cleared
      alert_out_n <= ~|(flags & ~mask[FLAG_W-1:0]);
      alert_oe_n_out <= ~|(flags & ~mask[FLAG_W-1:0]);
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    fault_word = '0;
    fault_word[FLAG_W-1:0] = flags;
    fault_word[DG_LATCH] = latched;
    fault_word[DG_PGOOD] = power_good_out;
    status_word = '0;
    status_word[SW_OTHER] = flags[DG_SHORT];
    status_word[SW_TEMP] = flags[DG_OTW] | flags[DG_OTF];
    status_word[SW_OFF] = ~gate_on_out;
    status_word[SW_PGOOD_N] = ~power_good_out;
    status_word[SW_INPUT] = flags[DG_UV] | flags[DG_OV] | flags[DG_OC];
    case (cmd)
      CMD_OPERATION: rd_word = {8'h00, op};
      CMD_OT_FAULT: rd_word = ot_fault_lim;
      CMD_OT_WARN: rd_word = ot_warn_lim;
      CMD_STATUS_WORD: rd_word = status_word;
      CMD_VENDOR_STATUS: rd_word = {15'h0000, flags[DG_SHORT]} << VS_SHORT;
      CMD_TEMP: rd_word = temp;
      CMD_ALERT_MASK: rd_word = mask;
      CMD_SETUP: rd_word = {8'h00, setup};
      CMD_FAULT_WORD: rd_word = fault_word;
      default: rd_word = 16'h0000;
    endcase
    rd_data = rd_idx ? rd_word[15:8] : rd_word[7:0];
  end
endmodule : hss_status_top

// >>> verif/hss_host.sv
// SMBus host model for the supervisor bench
`timescale 1ns/1ns
module hss_host (
  // Bus side
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // =====
  // Bus clock period of 80 ns; SDA moves in mid low phase, clear of both SCL edges
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tk;
    repeat (2) @(posedge clk_in);
  endtask : tk
  task automatic bt(input logic b, output logic v);
    tk;
    sda_out <= b;
    tk;
    scl_out <= 1'b1;
    tk;
    tk;
    v = sda_in;
    scl_out <= 1'b0;
  endtask : bt
  task automatic st;
    tk;
    sda_out <= 1'b1;
    tk;
    scl_out <= 1'b1;
    tk;
    sda_out <= 1'b0;
    tk;
    scl_out <= 1'b0;
  endtask : st
  task automatic sp;
    tk;
    sda_out <= 1'b0;
    tk;
    scl_out <= 1'b1;
    tk;
    sda_out <= 1'b1;
  endtask : sp
  task automatic wb(input logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--) bt(b[i], v);
    bt(1'b1, v);
  endtask : wb
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
    st;
    wb({hss_pkg::ADDR_BASE, 1'b0});
    wb(c);
    for (int i = 0; i < n; i++) wb(d[8*i+:8]);
    sp;
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    logic v;
    st;
    wb({hss_pkg::ADDR_BASE, 1'b0});
    wb(c);
    st;
    wb({hss_pkg::ADDR_BASE, 1'b1});
    for (int i = 0; i < 16; i++) begin
      bt(1'b1, d[7 - i % 8 + 8 * (i / 8)]);
      if (i % 8 == 7) bt(i > 8, v);
    end
    sp;
  endtask : rd
endmodule : hss_host

// >>> verif/hss_status_props.sv
// Concurrent checks on the supervisor top ports
`timescale 1ns/1ns
module hss_status_props #(
  parameter int MEAS_CYC = 100000,
  parameter int PULSE_LEN = 2000
) (
  // Watched ports
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic undervolt_enable_in,
  input wire logic overvolt_lockout_in,
  input wire logic ref_ok_in,
  input wire logic alert_out_n,
  input wire logic alert_oe_n_out,
  input wire logic gate_on_out,
  input wire logic power_good_out,
  input wire logic diode_pulse_out
);
  // =====
  // Pulse counters; a soft reset voids the pulse in flight
  int hi_cnt;
  int per_cnt;
  logic ok;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) hi_cnt <= 0;
    else hi_cnt <= diode_pulse_out ? hi_cnt + 1 : 0;
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) per_cnt <= 0;
    else per_cnt <= $rose(diode_pulse_out) ? 1 : per_cnt + 1;
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) ok <= 1'b0;
    else if (!ref_ok_in) ok <= 1'b0;
    else if ($rose(diode_pulse_out)) ok <= 1'b1;
  end
  sequence uv_low_s;
    !undervolt_enable_in [*4];
  endsequence
  sequence ov_high_s;
    overvolt_lockout_in [*4];
  endsequence
  sequence ref_low_s;
    !ref_ok_in [*4];
  endsequence
  AST_PG_UV: assert property (uv_low_s |-> !power_good_out) else $error("pg uv");
  AST_PG_OV: assert property (ov_high_s |-> !power_good_out) else $error("pg ov");
  AST_GATE_UV: assert property (uv_low_s |-> !gate_on_out) else $error("gate uv");
  AST_GATE_OV: assert property (ov_high_s |-> !gate_on_out) else $error("gate ov");
  AST_GATE_REF: assert property (ref_low_s |-> !gate_on_out) else $error("gate ref");
  AST_ALERT_OD: assert property (alert_out_n == alert_oe_n_out) else $error("alert oe");
  AST_PULSE_W: assert property ($fell(diode_pulse_out) && ok |-> hi_cnt == PULSE_LEN) else $error("width");
  AST_PULSE_P: assert property ($rose(diode_pulse_out) && ok |-> per_cnt == MEAS_CYC) else $error("gap");
endmodule : hss_status_props
bind hss_status_top hss_status_props #(.MEAS_CYC(MEAS_CYC), .PULSE_LEN(PULSE_LEN)) u_props (.clk_in, .rstn_in,
  .undervolt_enable_in, .overvolt_lockout_in, .ref_ok_in, .alert_out_n, .alert_oe_n_out, .gate_on_out,
  .power_good_out, .diode_pulse_out);

// >>> verif/hss_status_top_test.sv
// Self-checking bench of the hot-swap supervisor
`timescale 1ns/1ns
module hss_status_top_test;
  import hss_pkg::*;
  logic clk_in, rstn_in, uv, ov, so, fto, rok, scl, hsda, sda, oe_n, aln, gate, pg, fb, aoe;
  logic [15:0] tc, d;
  int failures = 0;
  int cmp_count = 0;
  assign sda = oe_n ? hsda : 1'b0;
  hss_status_top #(.MEAS_CYC(200), .PULSE_LEN(20), .RESTART_LEN(50)) DUT (.clk_in, .rstn_in,
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n_out(oe_n), .alert_out_n(aln), .alert_oe_n_out(aoe),
    .undervolt_enable_in(uv), .overvolt_lockout_in(ov), .feedback_in(fb), .sense_over_in(so),
    .fault_timeout_in(fto), .ref_ok_in(rok), .addr_strap_0_in(2'h0), .addr_strap_1_in(2'h0),
    .addr_strap_2_in(2'h0), .temp_code_in(tc), .gate_on_out(gate), .power_good_out(pg), .diode_pulse_out());
  hss_host u_host (.clk_in, .sda_in(sda), .scl_out(scl), .sda_out(hsda));
  // =====
  // Checking tasks
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic w(input int c);
    repeat (c) @(posedge clk_in);
  endtask : w
  task automatic rv(input logic [7:0] c, input logic [15:0] e, input string n);
    u_host.rd(c, d);
    chk(n, d, e);
  endtask : rv
  task automatic rb(input logic [7:0] c, input int b, input logic e, input string n);
    u_host.rd(c, d);
    chk(n, 16'(d[b]), 16'(e));
  endtask : rb
  task automatic print_verdict;
    $display("checks %0d errors %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    w(60000);
    failures++;
    print_verdict;
  end
  initial begin
    {rstn_in, ov, so, fto} = 4'h0;
    {uv, rok, fb} = 3'h7;
    tc = 16'h0019;
    w(5);
    rstn_in <= 1'b1;
    w(20);
    rv(CMD_OT_FAULT, 16'h0096, "flim");
    rv(CMD_OT_WARN, 16'h007D, "wlim");
    chk("gate", 16'(gate), 16'h1);
    rb(CMD_FAULT_WORD, 7, 1'b1, "pg fw");
    rb(CMD_STATUS_WORD, 11, 1'b0, "pg sw");
    u_host.wr(CMD_OPERATION, 16'h0000, 1);
    w(10);
    chk("op off", 16'(gate), 16'h0);
    u_host.wr(CMD_OT_WARN, 16'h0064, 2);
    uv <= 1'b0;
    w(10);
    chk("uv pg", 16'(pg), 16'h0);
    chk("uv al", 16'(aln), 16'h0);
    chk("uv oe", 16'(aoe), 16'h0);
    rb(CMD_FAULT_WORD, 1, 1'b1, "uv fw");
    uv <= 1'b1;
    ov <= 1'b1;
    w(10);
    rb(CMD_FAULT_WORD, 2, 1'b1, "ov fw");
    ov <= 1'b0;
    rv(CMD_OT_WARN, 16'h0064, "kept");
    u_host.wr(CMD_OPERATION, 16'h0080, 1);
    u_host.wr(CMD_CLEAR, 16'h0, 0);
    w(10);
    chk("op on", 16'(gate), 16'h1);
    chk("al clr", 16'(aln), 16'h1);
    chk("oe clr", 16'(aoe), 16'h1);
    tc <= 16'h0070;
    w(500);
    rv(CMD_TEMP, 16'h0070, "temp");
    chk("ot al", 16'(aln), 16'h0);
    tc <= 16'h00C8;
    w(500);
    chk("ot gate", 16'(gate), 16'h0);
    tc <= 16'h0019;
    w(500);
    u_host.wr(CMD_CLEAR, 16'h0, 0);
    u_host.wr(CMD_OPERATION, 16'h0000, 1);
    u_host.wr(CMD_OPERATION, 16'h0080, 1);
    w(10);
    chk("rearm", 16'(gate), 16'h1);
    u_host.wr(CMD_OPERATION, 16'h0000, 1);
    so <= 1'b1;
    w(10);
    rb(CMD_VENDOR_STATUS, 0, 1'b1, "short");
    chk("sh al", 16'(aln), 16'h0);
    u_host.wr(CMD_ALERT_MASK, 16'h0020, 2);
    u_host.wr(CMD_CLEAR, 16'h0, 0);
    w(10);
    chk("masked", 16'(aln), 16'h1);
    so <= 1'b0;
    u_host.wr(CMD_OPERATION, 16'h0080, 1);
    fto <= 1'b1;
    w(10);
    rb(CMD_FAULT_WORD, 6, 1'b1, "latch");
    fto <= 1'b0;
    uv <= 1'b0;
    w(10);
    uv <= 1'b1;
    w(10);
    chk("unlatch", 16'(gate), 16'h1);
    fb <= 1'b0;
    w(10);
    rb(CMD_FAULT_WORD, 7, 1'b0, "fb fw");
    rb(CMD_STATUS_WORD, 11, 1'b1, "fb sw");
    fb <= 1'b1;
    rok <= 1'b0;
    w(10);
    rok <= 1'b1;
    w(20);
    rv(CMD_ALERT_MASK, 16'h0000, "mrst");
    print_verdict;
  end
endmodule : hss_status_top_test
